// *** hw/bfto_top.sv ***
// Flag update and load time tag executor with APB registers
`timescale 1ns/10ps
module bfto_top #(
    parameter int TT_BITS = bfto_pkg::TT_W,
    parameter int CYC_PER_US = bfto_pkg::CYC_US
) (
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    input  wire logic                  ce,
    input  wire logic [bfto_pkg::AW-1:0] paddr,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [31:0]           pwdata,
    input  wire logic [3:0]            pstrb,
    output logic      [31:0]           prdata,
    output logic                       pready,
    output logic                       pslverr,
    input  wire logic                  instr_valid,
    output logic                       instr_ready,
    input  wire logic [bfto_pkg::OP_W-1:0]  instr_opcode,
    input  wire logic [bfto_pkg::PRM_W-1:0] instr_param,
    input  wire logic                  cond_true,
    input  wire logic                  cmp_valid,
    input  wire logic                  cmp_lt,
    input  wire logic                  cmp_eq,
    output logic                       fetch_next,
    output logic      [7:0]            flags,
    output logic      [TT_BITS-1:0]    ttag
);
    import bfto_pkg::*;

    // ****************************************************
    // Declarations
    // ****************************************************
    bfto_state_t   state;
    bfto_state_t   next_state;
    logic [15:0]   op_q;
    logic [15:0]   param_q;
    logic          cond_q;
    logic [2:0]    res;
    logic [2:0]    next_res;
    logic [3:0]    status;
    logic [3:0]    next_status;
    logic [31:0]   next_prdata;
    logic          slverr_q;
    logic          tt_tick;

    wire           take      = instr_valid && instr_ready;
    wire           in_exec   = state == S_EXEC;
    wire           is_flg    = op_q == OP_FLG;
    wire           is_ltt    = op_q == OP_LTT;
    wire           do_flg    = in_exec && is_flg;
    wire           do_ltt    = in_exec && is_ltt && cond_q;
    wire           skip_ltt  = in_exec && is_ltt && !cond_q;
    wire           apb_setup = psel && !penable;
    wire           apb_acc   = psel && penable && ce;
    wire           hit_cfg2  = paddr == REG_CFG2;
    wire           hit_flags = paddr == REG_FLAGS;
    wire           hit_ttag  = paddr == REG_TTAG;
    wire           hit_stat  = paddr == REG_STAT;
    wire           hit_any   = hit_cfg2 || hit_flags ||
                               hit_ttag || hit_stat;
    wire           cfg_wr    = apb_acc && pwrite && hit_cfg2;
    wire [31:0]    rd_cfg2   = 32'({res, 7'h00});
    wire [31:0]    rd_flags  = 32'(flags);
    wire [31:0]    rd_ttag   = 32'(ttag);
    wire [31:0]    rd_stat   = 32'(status);
    wire [15:0]    tt_value  = param_q;

    // ****************************************************
    // Instruction sequencing
    // ****************************************************
    assign instr_ready = state == S_IDLE;
    assign fetch_next  = state == S_NEXT;

    always_comb begin
        next_state = state;
        case (state)
            S_IDLE: begin
                if (instr_valid) begin
                    next_state = S_EXEC;
                end
            end
            // Either outcome of the test goes straight to fetch
            S_EXEC:  next_state = S_NEXT;
            S_NEXT:  next_state = S_IDLE;
            default: next_state = S_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= S_IDLE;
        end else if (ce) begin
            state <= next_state;
        end
    end

    // Condition sampled with the instruction, not while executing
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            op_q    <= 16'h0000;
            param_q <= 16'h0000;
            cond_q  <= 1'b0;
        end else if (ce && take) begin
            op_q    <= instr_opcode;
            param_q <= instr_param;
            cond_q  <= cond_true;
        end
    end

    // ****************************************************
    // Status of the last executed operation
    // ****************************************************
    always_comb begin
        next_status = status;
        next_status[ST_BUSY] = next_state != S_IDLE;
        if (in_exec) begin
            next_status[ST_LOADED] = do_ltt;
            next_status[ST_SKIP]   = skip_ltt;
            next_status[ST_FLG]    = do_flg;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status <= 4'h0;
        end else if (ce) begin
            status <= next_status;
        end
    end

    // ****************************************************
    // Datapath instances
    // ****************************************************
    bfto_flag_unit u_flags (
        .pclk      (pclk),
        .presetn   (presetn),
        .ce        (ce),
        .apply     (do_flg),
        .param     (param_q),
        .cmp_valid (cmp_valid),
        .cmp_lt    (cmp_lt),
        .cmp_eq    (cmp_eq),
        .flags     (flags)
    );

    bfto_ttag #(
        .W   (TT_BITS),
        .CYC (CYC_PER_US)
    ) u_ttag (
        .pclk     (pclk),
        .presetn  (presetn),
        .ce       (ce),
        .res      (res),
        .load     (do_ltt),
        .load_val (TT_BITS'(tt_value)),
        .count    (ttag),
        .tick     (tt_tick)
    );

    // ****************************************************
    // APB slave
    // ****************************************************
    // No wait states; a frozen block holds the bus instead
    assign pready  = ce;
    assign pslverr = slverr_q && psel && penable;

    // Read data registered in setup so the access phase is clean
    assign next_prdata = hit_cfg2  ? rd_cfg2  :
                         hit_flags ? rd_flags :
                         hit_ttag  ? rd_ttag  :
                         hit_stat  ? rd_stat  : 32'h0000_0000;

    // Field straddles two byte lanes
    assign next_res = {pstrb[1] ? pwdata[RES_LSB+2:RES_LSB+1]
                                : res[2:1],
                       pstrb[0] ? pwdata[RES_LSB] : res[0]};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata   <= 32'h0000_0000;
            slverr_q <= 1'b0;
        end else if (ce && apb_setup) begin
            prdata   <= pwrite ? 32'h0000_0000 : next_prdata;
            slverr_q <= !hit_any || (pwrite && !hit_cfg2);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            res <= RES_RST;
        end else if (cfg_wr) begin
            res <= next_res;
        end
    end

    // ****************************************************
    // Assertions
    // ****************************************************
    a_ltt_load: assert property (
        @(posedge pclk) disable iff (!presetn)
        ce && in_exec && is_ltt && cond_q
        |=> ttag == TT_BITS'($past(param_q)))
        else $error("time tag not loaded from parameter");

    a_ltt_skip: assert property (
        @(posedge pclk) disable iff (!presetn)
        ce && skip_ltt && !tt_tick |=> $stable(ttag))
        else $error("time tag changed on false condition");

    a_skip_fetch: assert property (
        @(posedge pclk) disable iff (!presetn)
        ce && skip_ltt |=> fetch_next)
        else $error("no fetch after skipped load");

    a_flg_effect: assert property (
        @(posedge pclk) disable iff (!presetn)
        ce && do_flg && !cmp_valid
        |=> flags == bfto_flag_apply($past(flags), $past(param_q)))
        else $error("flag update gave wrong flags");

    a_flg_pair: assert property (
        @(posedge pclk) disable iff (!presetn)
        ce && do_flg && !cmp_valid && param_q[15:8] == 8'h00
        |=> flags == ($past(flags) | $past(param_q[7:0])))
        else $error("flag set bits not on own flag");

    a_flg_uncond: assert property (
        @(posedge pclk) disable iff (!presetn)
        ce && do_flg && !cond_q && !cmp_valid && param_q == 16'h00ff
        |=> flags == 8'hff)
        else $error("flag update depended on condition");

    a_cmp_shared_top: assert property (
        @(posedge pclk) disable iff (!presetn)
        ce && cmp_valid |=> flags[1:0] == {$past(cmp_eq),
                                            $past(cmp_lt)})
        else $error("compare flags not shared");

    a_res_write: assert property (
        @(posedge pclk) disable iff (!presetn)
        cfg_wr && pstrb[1:0] == 2'b11
        |=> res == $past(pwdata[RES_LSB+2:RES_LSB]))
        else $error("resolution field not written");

    a_apb_unmap: assert property (@(posedge pclk) disable iff (!presetn)
        ce && apb_setup && !hit_any ##1 psel && penable |-> pslverr)
        else $error("unmapped address not flagged");

    // A stall after the take only stretches the execute cycle
    a_seq_len: assert property (
        @(posedge pclk) disable iff (!presetn)
        ce && take ##1 ce |-> in_exec ##1 fetch_next)
        else $error("instruction did not finish");

    // ****************************************************
    // Bus, status and freeze assertions
    // ****************************************************
    a_ce_freeze: assert property (
        @(posedge pclk) disable iff (!presetn)
        !ce |=> $stable(flags) && $stable(ttag) && $stable(res))
        else $error("state moved while clock enable was low");

    a_fetch_pulse: assert property (
        @(posedge pclk) disable iff (!presetn)
        ce && fetch_next |=> !fetch_next && instr_ready)
        else $error("fetch pulse longer than one cycle");

    a_busy_exec: assert property (
        @(posedge pclk) disable iff (!presetn)
        ce && take |=> in_exec && !instr_ready && status[ST_BUSY])
        else $error("taken instruction not executing");

    a_stat_load: assert property (
        @(posedge pclk) disable iff (!presetn)
        ce && do_ltt |=> status[ST_LOADED] && !status[ST_SKIP])
        else $error("load not recorded in status");

    a_stat_skip: assert property (
        @(posedge pclk) disable iff (!presetn)
        ce && skip_ltt |=> status[ST_SKIP] && !status[ST_LOADED])
        else $error("skip not recorded in status");

    a_ro_write: assert property (
        @(posedge pclk) disable iff (!presetn)
        ce && apb_setup && pwrite && hit_any && !hit_cfg2
        ##1 psel && penable |-> pslverr)
        else $error("write to read only register not flagged");

    a_rd_flags: assert property (
        @(posedge pclk) disable iff (!presetn)
        ce && apb_setup && !pwrite && hit_flags
        |=> prdata == 32'($past(flags)))
        else $error("flag register read gave wrong data");

    c_flg_exec: cover property (@(posedge pclk) disable iff (!presetn)
        ce && do_flg);
    c_apb_err: cover property (@(posedge pclk) disable iff (!presetn)
        ce && pslverr);
    c_ltt_load: cover property (@(posedge pclk) disable iff (!presetn)
        ce && do_ltt);
    c_ltt_skip: cover property (@(posedge pclk) disable iff (!presetn)
        ce && skip_ltt);
    c_cmp_flg: cover property (@(posedge pclk) disable iff (!presetn)
        ce && cmp_valid && do_flg);

endmodule : bfto_top

// *** hw/bfto_pkg.sv ***
// Constants, types and helpers for the flag and time tag operations
// Behaviour
// - Load time tag when condition is true
// - False condition skips load, fetches next
// - Flag n uses parameter bits n, n+8
// - Pair codes: keep, set, clear, toggle
// - Flags 0 and 1 shared with compares
package bfto_pkg;

    // ****************************************************
    // Opcodes and instruction fields
    // ****************************************************
    localparam int          OP_W      = 16;
    localparam int          PRM_W     = 16;
    localparam logic [15:0] OP_FLG    = 16'h000c;
    localparam logic [15:0] OP_LTT    = 16'h000d;
    localparam int          FLAG_N    = 8;
    localparam int          HI_OFS    = 8;
    localparam int          LT_BIT    = 0;
    localparam int          EQ_BIT    = 1;

    // ****************************************************
    // Timing
    // ****************************************************
    localparam int          CLK_NS    = 40;
    localparam int          US_NS     = 1000;
    localparam int          CYC_US    = (US_NS + CLK_NS - 1) / CLK_NS;
    localparam int          TT_W      = 16;

    // ****************************************************
    // Register map, fields and reset values
    // ****************************************************
    localparam int          AW        = 12;
    localparam logic [11:0] REG_CFG2  = 12'h000;
    localparam logic [11:0] REG_FLAGS = 12'h004;
    localparam logic [11:0] REG_TTAG  = 12'h008;
    localparam logic [11:0] REG_STAT  = 12'h00c;
    localparam int          RES_LSB   = 7;
    localparam int          RES_W     = 3;
    localparam logic [2:0]  RES_RST   = 3'h0;
    localparam int          ST_BUSY   = 0;
    localparam int          ST_LOADED = 1;
    localparam int          ST_SKIP   = 2;
    localparam int          ST_FLG    = 3;

    typedef enum logic [1:0] {
        S_IDLE,
        S_EXEC,
        S_NEXT
    } bfto_state_t;

    // ****************************************************
    // Flag pair decode
    // ****************************************************
    function automatic logic [7:0] bfto_flag_apply(
        input logic [7:0]  cur,
        input logic [15:0] prm
    );
        logic [7:0] res;
        res = cur;
        for (int i = 0; i < FLAG_N; i++) begin
            case ({prm[i + HI_OFS], prm[i]})
                2'b01:   res[i] = 1'b1;
                2'b10:   res[i] = 1'b0;
                2'b11:   res[i] = ~cur[i];
                default: res[i] = cur[i];
            endcase
        end
        return res;
    endfunction : bfto_flag_apply

endpackage : bfto_pkg

// *** hw/bfto_flag_unit.sv ***
// General purpose flag register with shared compare flags
`timescale 1ns/10ps
module bfto_flag_unit (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        ce,
    input  wire logic        apply,
    input  wire logic [15:0] param,
    input  wire logic        cmp_valid,
    input  wire logic        cmp_lt,
    input  wire logic        cmp_eq,
    output logic      [7:0]  flags
);
    import bfto_pkg::*;

    logic [7:0] upd_flags;
    logic [7:0] cmp_flags;
    logic [7:0] next_flags;

    // ****************************************************
    // Next value
    // ****************************************************
    // Compare result wins on bits 0 and 1 if both land together
    assign upd_flags  = apply ? bfto_flag_apply(flags, param)
                              : flags;
    assign cmp_flags  = {upd_flags[7:2], cmp_eq, cmp_lt};
    assign next_flags = cmp_valid ? cmp_flags : upd_flags;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flags <= 8'h00;
        end else if (ce) begin
            flags <= next_flags;
        end
    end

    a_cmp_shared: assert property (
        @(posedge pclk) disable iff (!presetn)
        ce && cmp_valid |=> flags[LT_BIT] == $past(cmp_lt) &&
                            flags[EQ_BIT] == $past(cmp_eq))
        else $error("compare result not in shared flags");

    a_flag_hold: assert property (
        @(posedge pclk) disable iff (!presetn)
        !(ce && (apply || cmp_valid)) |=> $stable(flags))
        else $error("flags changed without cause");

endmodule : bfto_flag_unit

// *** hw/bfto_ttag.sv ***
// Time tag counter with resolution prescaler and load
`timescale 1ns/10ps
module bfto_ttag #(
    parameter int W   = 16,
    parameter int CYC = 25
) (
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic         ce,
    input  wire logic [2:0]   res,
    input  wire logic         load,
    input  wire logic [W-1:0] load_val,
    output logic      [W-1:0] count,
    output logic              tick
);
    import bfto_pkg::*;

    localparam int CW = $clog2(CYC);
    localparam logic [CW-1:0] CYC_LAST = CW'(CYC - 1);

    logic [CW-1:0] cyc_cnt;
    logic [7:0]    us_cnt;
    logic [7:0]    us_last;
    logic          us_tick;

    // Resolution 2^res microseconds per count
    assign us_last = 8'(8'h01 << res) - 8'h01;
    assign us_tick = cyc_cnt == CYC_LAST;
    assign tick    = us_tick && (us_cnt == us_last);

    // Load restarts the prescaler so the first count is a full one
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cyc_cnt <= '0;
            us_cnt  <= 8'h00;
            count   <= '0;
        end else if (ce) begin
            if (load) begin
                cyc_cnt <= '0;
                us_cnt  <= 8'h00;
                count   <= load_val;
            end else begin
                cyc_cnt <= us_tick ? '0 : CW'(cyc_cnt + 1'b1);
                if (tick) begin
                    us_cnt <= 8'h00;
                    count  <= W'(count + 1'b1);
                end else if (us_tick) begin
                    us_cnt <= 8'(us_cnt + 8'h01);
                end
            end
        end
    end

    a_res_scale: assert property (
        @(posedge pclk) disable iff (!presetn)
        ce && !load && !tick |=> count == $past(count))
        else $error("time tag moved off a resolution tick");

endmodule : bfto_ttag

// *** tb/bfto_instr_src.sv ***
// Instruction list source standing in for the host
`timescale 1ns/10ps
module bfto_instr_src (
    input  wire logic        pclk,
    input  wire logic        instr_ready,
    input  wire logic        fetch_next,
    output logic             instr_valid,
    output logic      [15:0] instr_opcode,
    output logic      [15:0] instr_param,
    output logic             cond_true
);
    initial begin
        instr_valid  = 1'b0;
        instr_opcode = 16'h0000;
        instr_param  = 16'h0000;
        cond_true    = 1'b0;
    end

    // Offer one word, hold it until taken, then time the completion
    task automatic issue(input logic [15:0] op, input logic [15:0] prm,
                         input logic c, input int gap, output logic ok,
                         output logic [7:0] lat);
        int n;
        ok  = 1'b0;
        lat = 8'h00;
        repeat (gap + 1) @(posedge pclk);
        instr_valid  <= 1'b1;
        instr_opcode <= op;
        instr_param  <= prm;
        cond_true    <= c;
        for (n = 0; n < 16; n++) begin
            @(posedge pclk);
            if (instr_ready === 1'b1) break;
        end
        // Released lines show a changed pattern, never the old word
        instr_valid  <= 1'b0;
        instr_opcode <= ~op;
        instr_param  <= ~prm;
        cond_true    <= ~c;
        if (n == 16) return;
        for (n = 1; n <= 16; n++) begin
            @(posedge pclk);
            if (fetch_next === 1'b1) begin
                ok  = 1'b1;
                lat = 8'(n);
                return;
            end
        end
    endtask : issue
endmodule : bfto_instr_src

// *** tb/tb_top.sv ***
// Self-checking bench for the flag and time tag executor
`timescale 1ns/10ps
module tb_top;
    import bfto_pkg::*;
    // ****************************************
    // Clock, reset and design
    // ****************************************
    localparam int CYC = 2;  // Short microsecond keeps runs brief
    logic        pclk = 1'b0;
    logic        presetn, ce, psel, penable, pwrite, pready, pslverr;
    logic        iv, ir, cond, cv, clt, ceq, fn;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [3:0]  pstrb;
    logic [15:0] iop, iprm, ttag;
    logic [7:0]  flags;
    int          failures = 0;
    int          n_compared = 0;

    always #20 pclk = ~pclk;

    bfto_top #(.TT_BITS(16), .CYC_PER_US(CYC)) dut_u (
        .pclk(pclk), .presetn(presetn), .ce(ce), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .instr_valid(iv), .instr_ready(ir), .instr_opcode(iop),
        .instr_param(iprm), .cond_true(cond), .cmp_valid(cv),
        .cmp_lt(clt), .cmp_eq(ceq), .fetch_next(fn), .flags(flags),
        .ttag(ttag));

    bfto_instr_src src_u (
        .pclk(pclk), .instr_ready(ir), .fetch_next(fn), .instr_valid(iv),
        .instr_opcode(iop), .instr_param(iprm), .cond_true(cond));

    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic results();
        if (failures == 0 && n_compared > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : results

    task automatic chk(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] wd, output logic [31:0] rd,
                       output logic err);
        int n;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        for (n = 0; n < 20; n++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (n == 20) begin
            failures++;
            results();
        end
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic run(input logic [15:0] op, input logic [15:0] prm,
                       input logic c, input int gap, output logic [7:0] lat);
        logic ok;
        src_u.issue(op, prm, c, gap, ok, lat);
        if (ok !== 1'b1) begin
            failures++;
            results();
        end
    endtask : run

    // Own model of the pair codes: keep, set, clear, toggle
    function automatic logic [7:0] fexp(input logic [7:0] cur,
                                        input logic [15:0] p);
        logic [7:0] hi, lo;
        hi = p[15:8];
        lo = p[7:0];
        return (cur & ~hi & ~lo) | (~hi & lo) | (~cur & hi & lo);
    endfunction : fexp

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_regs();
        logic [31:0] rd;
        logic        err;
        apb(1'b0, REG_CFG2, 32'h0, rd, err);
        chk("cfg2_reset", rd, 32'h0);
        apb(1'b0, 12'h010, 32'h0, rd, err);
        chk("unmapped_err", {31'h0, err}, 32'h1);
        apb(1'b1, REG_FLAGS, 32'hff, rd, err);
        chk("ro_write_err", {31'h0, err}, 32'h1);
        chk("ro_no_effect", {24'h0, flags}, 32'h0);
        apb(1'b1, REG_CFG2, 32'h7 << RES_LSB, rd, err);
        apb(1'b0, REG_CFG2, 32'h0, rd, err);
        chk("res_field", {29'h0, rd[9:7]}, 32'h7);
        // Lane 0 alone reaches bit 7 only
        pstrb <= 4'h1;
        apb(1'b1, REG_CFG2, 32'h0, rd, err);
        pstrb <= 4'hf;
        apb(1'b0, REG_CFG2, 32'h0, rd, err);
        chk("res_lane", {29'h0, rd[9:7]}, 32'h6);
    endtask : t_regs

    task automatic t_flags();
        logic [15:0] p [4] = '{16'h00ff, 16'hf00f, 16'hccaa, 16'h2000};
        logic [7:0]  e, lat;
        logic [31:0] rd;
        logic        err;
        foreach (p[i]) begin
            e = fexp(flags, p[i]);
            run(OP_FLG, p[i], 1'b0, i, lat);
            chk("flags", {24'h0, flags}, {24'h0, e});
        end
        apb(1'b0, REG_FLAGS, 32'h0, rd, err);
        chk("flags_reg", rd, 32'h83);
    endtask : t_flags

    task automatic t_cmp();
        logic [7:0] lat;
        @(posedge pclk);
        cv  <= 1'b1;
        clt <= 1'b1;
        ceq <= 1'b0;
        @(posedge pclk);
        cv  <= 1'b0;
        @(posedge pclk);
        chk("cmp_lt", {24'h0, flags}, 32'h81);
        run(OP_FLG, 16'h0303, 1'b1, 0, lat);
        chk("shared_toggle", {24'h0, flags}, 32'h82);
    endtask : t_cmp

    task automatic t_ltt();
        logic [7:0] lat;
        run(OP_LTT, 16'ha5c3, 1'b1, 0, lat);
        chk("ttag_load", {16'h0, ttag}, 32'ha5c3);
        run(OP_LTT, 16'h1234, 1'b0, 3, lat);
        chk("ttag_kept", {16'h0, ttag}, 32'ha5c3);
        chk("skip_latency", {24'h0, lat}, 32'h2);
        run(16'h0007, 16'hffff, 1'b1, 0, lat);
        chk("other_op", {8'h0, ttag, flags}, 32'ha5c382);
    endtask : t_ltt

    // Long resolution codes would need hundreds of cycles; low codes only
    task automatic t_res();
        logic [31:0] rd;
        logic        err;
        logic [7:0]  lat;
        logic [15:0] d, e;
        logic        in_rng;
        for (int r = 0; r < 3; r++) begin
            apb(1'b1, REG_CFG2, 32'(r) << RES_LSB, rd, err);
            run(OP_LTT, 16'h0100, 1'b1, 0, lat);
            repeat (40) @(posedge pclk);
            d = ttag - 16'h0100;
            e = 16'(40 / (CYC << r));
            in_rng = d + 1 >= e && d <= e + 1;
            chk("res_rate", {31'h0, in_rng}, 32'h1);
        end
    endtask : t_res

    // Frozen block holds its state and stalls the bus
    task automatic t_ce();
        logic [15:0] tt;
        logic [7:0]  fl;
        @(posedge pclk);
        ce <= 1'b0;
        @(posedge pclk);
        tt = ttag;
        fl = flags;
        repeat (12) @(posedge pclk);
        chk("ce_ttag", {16'h0, ttag}, {16'h0, tt});
        chk("ce_flags", {24'h0, flags}, {24'h0, fl});
        chk("ce_ready", {31'h0, pready}, 32'h0);
        ce <= 1'b1;
    endtask : t_ce

    initial begin
        presetn = 1'b0;
        ce      = 1'b1;
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 12'h000;
        pwdata  = 32'h0;
        pstrb   = 4'hf;
        cv      = 1'b0;
        clt     = 1'b0;
        ceq     = 1'b0;
        repeat (8) @(posedge pclk);
        chk("reset_out", {8'h0, ttag, flags}, 32'h0);
        presetn <= 1'b1;
        t_regs();
        t_flags();
        t_cmp();
        t_ltt();
        t_res();
        t_ce();
        results();
    end
endmodule : tb_top
